// ---- logic/hcs_pkg.sv ----
// Shared constants for the host configuration space register block
package hcs_pkg;
	// ----------------------------------------
	// Configuration space offsets
	// ----------------------------------------
	localparam logic [7:0] CFG_ID = 8'h00;
	localparam logic [7:0] CFG_STCMD = 8'h04;
	localparam logic [7:0] CFG_CLASS = 8'h08;
	localparam logic [7:0] CFG_BAR = 8'h10;
	localparam logic [7:0] CFG_SUBSYS = 8'h2C;
	// ----------------------------------------
	// Status and command fields
	// ----------------------------------------
	localparam int ST_PERR = 31;
	localparam int ST_SERR = 30;
	localparam int CMD_INTDIS = 10;
	localparam int CMD_SERREN = 8;
	localparam int CMD_PERREN = 6;
	localparam int CMD_MEMEN = 1;
	localparam logic [15:0] CMD_WMASK = 16'h0542;
	localparam logic [15:0] CMD_RST = 16'h0000;
	localparam logic [3:0] ST_HI_RST = 4'h0;
	localparam logic CAP_LIST = 1'b1;
	localparam logic [23:0] CLASS_RST = 24'h070002;
	localparam logic [15:0] SUBSYS_RST = 16'h0000;
	// ----------------------------------------
	// Memory window
	// ----------------------------------------
	localparam int BAR_LSB = 14;
	localparam int WIN_BITS = 13;
	localparam logic [17:0] BAR_RST = 18'h00000;
	localparam logic [12:0] MEM_INT0 = 13'h0080;
	localparam int INT_REGS = 4;
	localparam logic [12:0] MEM_EEACC = 13'h0090;
	localparam int EEA_SK = 0;
	localparam int EEA_CS = 1;
	localparam int EEA_DI = 2;
	// ----------------------------------------
	// Expansion slave kinds
	// ----------------------------------------
	localparam logic [1:0] KIND_SAME = 2'h1;
	localparam logic [1:0] KIND_SMALL = 2'h2;
	// ----------------------------------------
	// Serial EEPROM
	// ----------------------------------------
	localparam int EE_WORDS = 8;
	localparam int EE_ADDR_W = 6;
	localparam logic [1:0] EE_OP_READ = 2'h2;
	localparam int EE_CMD_BITS = 9;
	localparam int EE_DATA_FIRST = 9;
	localparam int EE_LAST_BIT = 24;
	localparam logic [15:0] EE_BLANK = 16'hFFFF;
	localparam int EEW_VENDOR = 0;
	localparam int EEW_SUBVEN = 1;
	localparam int EEW_DEVID = 2;
	localparam int EEW_SUBSYS = 3;
	localparam int EEW_CLASS_HI = 4;
	localparam int EEW_CLASS_LO = 5;
	localparam int CLK_NS = 25;
	localparam int EE_HALF_NS = 500;
	localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- logic/hcs_ee_reader.sv ----
// Serial EEPROM reader that fetches the auto-configuration words after reset
`timescale 1ns/10ps
module hcs_ee_reader #(
	parameter int HALF_CYC = hcs_pkg::EE_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Serial memory pins, data out already synchronised
	output logic cs,
	output logic sk,
	output logic di,
	input wire logic do_s,
	// Loaded words
	output logic wr_stb,
	output logic [2:0] wr_idx,
	output logic [15:0] wr_data,
	output logic done
);
	localparam int TW = $clog2(HALF_CYC + 1);
	localparam logic [TW-1:0] RELOAD = TW'(HALF_CYC - 1);
	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least one");
	end
	typedef enum logic [1:0] {RD_GAP, RD_LO, RD_HI, RD_DONE} hcs_rd_t;
	hcs_rd_t st_r, st_nxt;
	logic [TW-1:0] tmr_r, tmr_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic [2:0] word_r, word_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic cs_r, cs_nxt, sk_r, sk_nxt, di_r, di_nxt, stb_r, stb_nxt;
	logic [8:0] cmd;
	assign cmd = {1'b1, hcs_pkg::EE_OP_READ, {(hcs_pkg::EE_ADDR_W - 3){1'b0}}, word_r};
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		bit_nxt = bit_r;
		word_nxt = word_r;
		sh_nxt = sh_r;
		cs_nxt = cs_r;
		sk_nxt = sk_r;
		di_nxt = di_r;
		stb_nxt = 1'b0;
		if (tmr_r != '0) begin
			tmr_nxt = tmr_r - 1'b1;
		end else begin
			tmr_nxt = RELOAD;
			case (st_r)
				RD_GAP: begin
					cs_nxt = 1'b1;
					bit_nxt = '0;
					di_nxt = cmd[hcs_pkg::EE_CMD_BITS-1];
					st_nxt = RD_LO;
				end
				RD_LO: begin
					sk_nxt = 1'b1;
					st_nxt = RD_HI;
				end
				RD_HI: begin
					sk_nxt = 1'b0;
					if (bit_r >= 5'(hcs_pkg::EE_DATA_FIRST)) sh_nxt = {sh_r[14:0], do_s};
					if (bit_r == 5'(hcs_pkg::EE_LAST_BIT)) begin
						cs_nxt = 1'b0;
						di_nxt = 1'b0;
						stb_nxt = 1'b1;
						word_nxt = word_r + 1'b1;
						st_nxt = (word_r == 3'(hcs_pkg::EE_WORDS - 1)) ? RD_DONE : RD_GAP;
					end else begin
						bit_nxt = bit_r + 1'b1;
						if (bit_r < 5'(hcs_pkg::EE_CMD_BITS - 1)) di_nxt = cmd[4'(hcs_pkg::EE_CMD_BITS - 2) - bit_r[3:0]];
						else di_nxt = 1'b0;
						st_nxt = RD_LO;
					end
				end
				RD_DONE: tmr_nxt = '0;
				default: st_nxt = RD_DONE;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= RD_GAP;
			tmr_r <= RELOAD;
			bit_r <= '0;
			word_r <= '0;
			sh_r <= '0;
			cs_r <= 1'b0;
			sk_r <= 1'b0;
			di_r <= 1'b0;
			stb_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			word_r <= word_nxt;
			sh_r <= sh_nxt;
			cs_r <= cs_nxt;
			sk_r <= sk_nxt;
			di_r <= di_nxt;
			stb_r <= stb_nxt;
		end
	end
	assign cs = cs_r;
	assign sk = sk_r;
	assign di = di_r;
	assign wr_stb = stb_r;
	assign wr_idx = word_r - 1'b1;
	assign wr_data = sh_r;
	assign done = (st_r == RD_DONE);
endmodule

// ---- logic/hcs_regs.sv ----
// Configuration space registers, memory window decode and EEPROM loading
`timescale 1ns/10ps
// Behaviour
// - Word 0x00 bits 31:16 give a device identifier chosen by the attached expansion slave, EEPROM may override it.
// - Word 0x00 bits 15:0 give the vendor identifier, loadable from EEPROM and read-only to the host.
// - Status bit 31 sets on a parity error, resets to zero and clears when the host writes one.
// - Status bit 30 sets on a system error, resets to zero, clears on a written one, a written zero does nothing.
// - Status bits 29:24 are read-only and always read zero.
// - Status bits 23:21 are read-only and read zero.
// - The host writes the memory base into the register at 0x10 and memory accesses decode against it.
// - Device and channel registers are reached as memory through an 8K byte window.
// - The EEPROM is worked through four pins: data out, data in, select and clock.
// - Vendor, sub-vendor and four more words are read from EEPROM into the matching fields.
// - Without an EEPROM the fields keep their built-in defaults.
// - Software reaches the EEPROM pins through a device register for general storage.
// - Four consecutive interrupt source registers report all interrupt status.
// - Identity, resource and capability fields are readable for enumeration once the EEPROM load ends; earlier accesses are retried.
// - Command bit 1 gates memory decoding, resets to zero and is set by the host.
module hcs_regs #(
	parameter logic [15:0] VENDOR_ID = 16'h1F00, // Arbitrary value
	parameter logic [15:0] DEV_ID_NONE = 16'h0A00, // Arbitrary value
	parameter logic [15:0] DEV_ID_SAME = 16'h0A01, // Arbitrary value
	parameter logic [15:0] DEV_ID_SMALL = 16'h0A02, // Arbitrary value
	parameter logic [7:0] REV_ID = 8'h01, // Arbitrary value
	parameter int EE_HALF = hcs_pkg::EE_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Configuration access
	input wire logic cfg_req,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic cfg_retry,
	output logic [31:0] cfg_rdata,
	// Memory access
	input wire logic mem_req,
	input wire logic mem_wr,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_claim,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	output logic mem_fwd,
	output logic mem_fwd_wr,
	output logic [12:0] mem_fwd_off,
	output logic [31:0] mem_fwd_wdata,
	// Events and sources
	input wire logic parity_err_evt,
	input wire logic sys_err_evt,
	input wire logic [127:0] irq_src,
	input wire logic [1:0] slave_kind,
	// Serial EEPROM pins
	output logic eeprom_select,
	output logic eeprom_serial_clock,
	output logic eeprom_serial_to_memory,
	input wire logic eeprom_serial_from_memory,
	// Command state
	output logic cmd_mem_en,
	output logic cmd_int_dis,
	output logic cmd_serr_en,
	output logic cmd_perr_en,
	output logic load_done
);
	initial begin
		if (hcs_pkg::INT_REGS * 32 != 128) $error("irq_src width must match the interrupt registers");
	end
	// ----------------------------------------
	// Synchronisers and EEPROM reader
	// ----------------------------------------
	logic do_m_r, do_s_r;
	logic [1:0] kind_m_r, kind_s_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			do_m_r <= 1'b0;
			do_s_r <= 1'b0;
			kind_m_r <= 2'h0;
			kind_s_r <= 2'h0;
		end else begin
			do_m_r <= eeprom_serial_from_memory;
			do_s_r <= do_m_r;
			kind_m_r <= slave_kind;
			kind_s_r <= kind_m_r;
		end
	end
	logic rd_cs, rd_sk, rd_di, ee_stb, ee_done;
	logic [2:0] ee_idx;
	logic [15:0] ee_data;
	hcs_ee_reader #(.HALF_CYC(EE_HALF)) u_rd (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.cs(rd_cs),
		.sk(rd_sk),
		.di(rd_di),
		.do_s(do_s_r),
		.wr_stb(ee_stb),
		.wr_idx(ee_idx),
		.wr_data(ee_data),
		.done(ee_done)
	);
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [15:0] ven_r, ven_nxt, subven_r, subven_nxt, devee_r, devee_nxt, subsys_r, subsys_nxt;
	logic [23:0] class_r, class_nxt;
	logic devovr_r, devovr_nxt, eeok_r, eeok_nxt;
	logic [15:0] cmd_r, cmd_nxt;
	logic perr_r, perr_nxt, serr_r, serr_nxt;
	logic [17:0] bar_r, bar_nxt;
	logic ack_r, ack_nxt, retry_r, retry_nxt;
	logic [31:0] rdata_r, rdata_nxt, mask, dev_word, bar_new, rd_val;
	logic [15:0] dev_id, cmd_new;
	logic cfg_we, ee_we;
	assign mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
	assign cfg_we = cfg_req && cfg_wr && ee_done;
	assign ee_we = ee_stb && (ee_idx == 3'(hcs_pkg::EEW_VENDOR) ? ee_data != hcs_pkg::EE_BLANK : eeok_r);
	always_comb begin
		if (devovr_r) dev_id = devee_r;
		else if (kind_s_r == hcs_pkg::KIND_SAME) dev_id = DEV_ID_SAME;
		else if (kind_s_r == hcs_pkg::KIND_SMALL) dev_id = DEV_ID_SMALL;
		else dev_id = DEV_ID_NONE;
	end
	assign dev_word = {dev_id, ven_r};
	assign bar_new = ({bar_r, {hcs_pkg::BAR_LSB{1'b0}}} & ~mask) | (cfg_wdata & mask);
	assign cmd_new = ((cmd_r & ~mask[15:0]) | (cfg_wdata[15:0] & mask[15:0])) & hcs_pkg::CMD_WMASK;
	always_comb begin
		case (cfg_addr)
			hcs_pkg::CFG_ID: rd_val = dev_word;
			hcs_pkg::CFG_STCMD: rd_val = {perr_r, serr_r, 9'h000, hcs_pkg::CAP_LIST, hcs_pkg::ST_HI_RST, cmd_r};
			hcs_pkg::CFG_CLASS: rd_val = {class_r, REV_ID};
			hcs_pkg::CFG_BAR: rd_val = {bar_r, {hcs_pkg::BAR_LSB{1'b0}}};
			hcs_pkg::CFG_SUBSYS: rd_val = {subsys_r, subven_r};
			default: rd_val = 32'h00000000;
		endcase
	end
	always_comb begin
		ven_nxt = ven_r;
		subven_nxt = subven_r;
		devee_nxt = devee_r;
		devovr_nxt = devovr_r;
		subsys_nxt = subsys_r;
		class_nxt = class_r;
		eeok_nxt = eeok_r;
		cmd_nxt = cmd_r;
		bar_nxt = bar_r;
		perr_nxt = perr_r;
		serr_nxt = serr_r;
		ack_nxt = cfg_req && ee_done;
		retry_nxt = cfg_req && !ee_done;
		rdata_nxt = rdata_r;
		if (ee_stb && ee_idx == 3'(hcs_pkg::EEW_VENDOR)) eeok_nxt = ee_data != hcs_pkg::EE_BLANK;
		if (ee_we) begin
			case (ee_idx)
				3'(hcs_pkg::EEW_VENDOR): ven_nxt = ee_data;
				3'(hcs_pkg::EEW_SUBVEN): subven_nxt = ee_data;
				3'(hcs_pkg::EEW_DEVID): begin
					devee_nxt = ee_data;
					devovr_nxt = 1'b1;
				end
				3'(hcs_pkg::EEW_SUBSYS): subsys_nxt = ee_data;
				3'(hcs_pkg::EEW_CLASS_HI): class_nxt[23:8] = ee_data;
				3'(hcs_pkg::EEW_CLASS_LO): class_nxt[7:0] = ee_data[7:0];
				default: ;
			endcase
		end
		if (cfg_req && !cfg_wr && ee_done) rdata_nxt = rd_val;
		if (cfg_we && cfg_addr == hcs_pkg::CFG_STCMD) begin
			cmd_nxt = cmd_new;
			if (cfg_wdata[hcs_pkg::ST_PERR] && cfg_be[3]) perr_nxt = 1'b0;
			if (cfg_wdata[hcs_pkg::ST_SERR] && cfg_be[3]) serr_nxt = 1'b0;
		end
		if (cfg_we && cfg_addr == hcs_pkg::CFG_BAR) bar_nxt = bar_new[31:hcs_pkg::BAR_LSB];
		if (parity_err_evt) perr_nxt = 1'b1;
		if (sys_err_evt) serr_nxt = 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ven_r <= VENDOR_ID;
			subven_r <= hcs_pkg::SUBSYS_RST;
			devee_r <= DEV_ID_NONE;
			devovr_r <= 1'b0;
			subsys_r <= hcs_pkg::SUBSYS_RST;
			class_r <= hcs_pkg::CLASS_RST;
			eeok_r <= 1'b0;
			cmd_r <= hcs_pkg::CMD_RST;
			bar_r <= hcs_pkg::BAR_RST;
			perr_r <= 1'b0;
			serr_r <= 1'b0;
			ack_r <= 1'b0;
			retry_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ven_r <= ven_nxt;
			subven_r <= subven_nxt;
			devee_r <= devee_nxt;
			devovr_r <= devovr_nxt;
			subsys_r <= subsys_nxt;
			class_r <= class_nxt;
			eeok_r <= eeok_nxt;
			cmd_r <= cmd_nxt;
			bar_r <= bar_nxt;
			perr_r <= perr_nxt;
			serr_r <= serr_nxt;
			ack_r <= ack_nxt;
			retry_r <= retry_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign cfg_ack = ack_r;
	assign cfg_retry = retry_r;
	assign cfg_rdata = rdata_r;
	assign cmd_mem_en = cmd_r[hcs_pkg::CMD_MEMEN];
	assign cmd_int_dis = cmd_r[hcs_pkg::CMD_INTDIS];
	assign cmd_serr_en = cmd_r[hcs_pkg::CMD_SERREN];
	assign cmd_perr_en = cmd_r[hcs_pkg::CMD_PERREN];
	assign load_done = ee_done;
	// ----------------------------------------
	// Memory window
	// ----------------------------------------
	logic [12:0] off;
	logic is_int, is_eea;
	logic mack_r, mack_nxt, fwd_r, fwd_nxt, fwr_r, fwr_nxt;
	logic [12:0] foff_r, foff_nxt;
	logic [31:0] mrd_r, mrd_nxt, fwd_d_r, fwd_d_nxt;
	logic [2:0] eea_r, eea_nxt;
	assign off = mem_addr[hcs_pkg::WIN_BITS-1:0];
	assign mem_claim = mem_req && cmd_r[hcs_pkg::CMD_MEMEN] && mem_addr[31:hcs_pkg::BAR_LSB] == bar_r &&
		mem_addr[hcs_pkg::BAR_LSB-1:hcs_pkg::WIN_BITS] == '0;
	assign is_int = off >= hcs_pkg::MEM_INT0 && off < hcs_pkg::MEM_INT0 + 13'(4 * hcs_pkg::INT_REGS);
	assign is_eea = off == hcs_pkg::MEM_EEACC;
	always_comb begin
		mack_nxt = mem_claim && (is_int || is_eea);
		fwd_nxt = mem_claim && !(is_int || is_eea);
		fwr_nxt = fwd_nxt ? mem_wr : fwr_r;
		foff_nxt = fwd_nxt ? off : foff_r;
		fwd_d_nxt = fwd_nxt ? mem_wdata : fwd_d_r;
		mrd_nxt = mrd_r;
		eea_nxt = eea_r;
		if (mem_claim && is_int && !mem_wr) mrd_nxt = irq_src[{off[3:2], 5'h00} +: 32];
		if (mem_claim && is_eea && !mem_wr) mrd_nxt = {28'h0000000, do_s_r, eea_r};
		if (mem_claim && is_eea && mem_wr) eea_nxt = mem_wdata[2:0];
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mack_r <= 1'b0;
			fwd_r <= 1'b0;
			fwr_r <= 1'b0;
			foff_r <= 13'h0000;
			fwd_d_r <= 32'h00000000;
			mrd_r <= 32'h00000000;
			eea_r <= 3'h0;
		end else begin
			mack_r <= mack_nxt;
			fwd_r <= fwd_nxt;
			fwr_r <= fwr_nxt;
			foff_r <= foff_nxt;
			fwd_d_r <= fwd_d_nxt;
			mrd_r <= mrd_nxt;
			eea_r <= eea_nxt;
		end
	end
	assign mem_ack = mack_r;
	assign mem_rdata = mrd_r;
	assign mem_fwd = fwd_r;
	assign mem_fwd_wr = fwr_r;
	assign mem_fwd_off = foff_r;
	assign mem_fwd_wdata = fwd_d_r;
	assign eeprom_select = ee_done ? eea_r[hcs_pkg::EEA_CS] : rd_cs;
	assign eeprom_serial_clock = ee_done ? eea_r[hcs_pkg::EEA_SK] : rd_sk;
	assign eeprom_serial_to_memory = ee_done ? eea_r[hcs_pkg::EEA_DI] : rd_di;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_retry;
		cfg_req && !ee_done |=> cfg_retry && !cfg_ack;
	endproperty
	a_retry: assert property (p_retry) else $error("access not retried during load");
	property p_perr;
		parity_err_evt |=> perr_r ##1 (perr_r || $past(cfg_we));
	endproperty
	a_perr: assert property (p_perr) else $error("parity flag lost");
	property p_serr_w0;
		cfg_we && cfg_addr == hcs_pkg::CFG_STCMD && !cfg_wdata[hcs_pkg::ST_SERR] && serr_r |=> serr_r;
	endproperty
	a_serr_w0: assert property (p_serr_w0) else $error("zero write cleared system flag");
	property p_serr_w1;
		cfg_we && cfg_addr == hcs_pkg::CFG_STCMD && cfg_wdata[hcs_pkg::ST_SERR] && cfg_be[3] && !sys_err_evt
			|=> !serr_r;
	endproperty
	a_serr_w1: assert property (p_serr_w1) else $error("one write did not clear system flag");
	property p_st_zero;
		cfg_req && !cfg_wr && ee_done && cfg_addr == hcs_pkg::CFG_STCMD |=> cfg_ack && cfg_rdata[29:21] == 9'h000;
	endproperty
	a_st_zero: assert property (p_st_zero) else $error("read-only status bits not zero");
	property p_memgate;
		mem_req && !cmd_mem_en |=> !mem_ack && !mem_fwd;
	endproperty
	a_memgate: assert property (p_memgate) else $error("memory claimed while disabled");
	property p_bar;
		mem_req && mem_addr[31:hcs_pkg::BAR_LSB] != bar_r |=> !mem_ack && !mem_fwd;
	endproperty
	a_bar: assert property (p_bar) else $error("claim outside base");
	property p_vendor;
		cfg_req && !cfg_wr && ee_done && cfg_addr == hcs_pkg::CFG_ID |=> cfg_rdata[15:0] == ven_r;
	endproperty
	a_vendor: assert property (p_vendor) else $error("vendor field wrong");
	property p_devid;
		cfg_req && !cfg_wr && ee_done && cfg_addr == hcs_pkg::CFG_ID && !devovr_r && kind_s_r == 2'h0
			|=> cfg_rdata[31:16] == DEV_ID_NONE;
	endproperty
	a_devid: assert property (p_devid) else $error("device identifier wrong");
	property p_irq;
		mem_claim && !mem_wr && off == hcs_pkg::MEM_INT0 |=> mem_ack && mem_rdata == $past(irq_src[31:0]);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt source read wrong");
	property p_eea;
		ee_done && mem_claim && mem_wr && is_eea |=> eeprom_select == $past(mem_wdata[hcs_pkg::EEA_CS]);
	endproperty
	a_eea: assert property (p_eea) else $error("select pin not under software");
	c_load: cover property (ee_we && ee_idx == 3'(hcs_pkg::EEW_CLASS_LO));
	c_bar: cover property (cfg_we && cfg_addr == hcs_pkg::CFG_BAR);
	c_fwd: cover property (mem_fwd);
	c_clear_race: cover property (parity_err_evt && cfg_we && cfg_addr == hcs_pkg::CFG_STCMD);
endmodule

// ---- sim/hcs_ee_model.sv ----
// Behavioural serial EEPROM that answers read commands
`timescale 1ns/10ps
module hcs_ee_model #(
	parameter logic [127:0] WORDS = 128'h0
) (
	// Memory pins
	input wire logic cs,
	input wire logic sk,
	input wire logic di,
	output logic dout
);
	int cnt = 0;
	logic [8:0] cmd = 9'h000;
	logic [15:0] word = 16'h0000;
	logic dout_r = 1'b1;
	assign dout = dout_r;
	// ----------------------------------------
	// Deselect, command in, data out
	// ----------------------------------------
	// Released line shows the inverse of its last value
	// Start bit and read opcode must arrive before data goes out
	always @(posedge sk or negedge cs) begin
		if (!cs) begin
			cnt = 0;
			dout_r = ~dout_r;
		end else begin
			if (cnt < 9) begin
				cmd = {cmd[7:0], di};
			end
			if (cnt >= 9 && cnt < 25 && cmd[8:6] == 3'h6) begin
				word = WORDS[16 * cmd[2:0] +: 16];
				dout_r = word[24 - cnt];
			end
			cnt = cnt + 1;
		end
	end
endmodule

// ---- sim/tb_host_config_space_regs.sv ----
// Self-checking testbench for the configuration space register block
`timescale 1ns/10ps
module tb_host_config_space_regs;
	localparam int EE_H = 4;
	localparam int LIMIT = 10000;
	localparam logic [31:0] BASE = 32'h1234_4000;
	localparam logic [127:0] EE_DATA = 128'h2222_1111_0010_0C03_7081_5E6F_3C4D_1A2B;
	logic clk_sys = 1'b0, rst_b = 1'b0;
	logic cfg_req = 1'b0, cfg_wr = 1'b0, mem_req = 1'b0, mem_wr = 1'b0;
	logic parity_err_evt = 1'b0, sys_err_evt = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_be = 4'hF;
	logic [31:0] cfg_wdata = 32'h0, mem_addr = 32'h0, mem_wdata = 32'h0;
	logic [127:0] irq_src = 128'hDDDD_0004_CCCC_0003_BBBB_0002_AAAA_0001;
	logic [1:0] slave_kind = 2'h0;
	logic cfg_ack, cfg_retry, mem_claim, mem_ack, mem_fwd, mem_fwd_wr, load_done, load_done2;
	logic ee_cs, ee_sk, ee_di, ee_do, cmd_mem_en, cmd_int_dis, cmd_serr_en, cmd_perr_en;
	logic [31:0] cfg_rdata, cfg_rdata2, mem_rdata, mem_fwd_wdata;
	logic [12:0] mem_fwd_off;
	logic [15:0] ids [4] = '{16'h0A00, 16'h0A01, 16'h0A02, 16'h0A00};
	int failures = 0, samples_checked = 0, cycles = 0;

	hcs_regs #(.EE_HALF(EE_H)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_retry(cfg_retry),
		.cfg_rdata(cfg_rdata), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_claim(mem_claim), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fwd(mem_fwd),
		.mem_fwd_wr(mem_fwd_wr), .mem_fwd_off(mem_fwd_off), .mem_fwd_wdata(mem_fwd_wdata),
		.parity_err_evt(parity_err_evt), .sys_err_evt(sys_err_evt), .irq_src(irq_src), .slave_kind(slave_kind),
		.eeprom_select(ee_cs), .eeprom_serial_clock(ee_sk), .eeprom_serial_to_memory(ee_di),
		.eeprom_serial_from_memory(ee_do), .cmd_mem_en(cmd_mem_en), .cmd_int_dis(cmd_int_dis),
		.cmd_serr_en(cmd_serr_en), .cmd_perr_en(cmd_perr_en), .load_done(load_done));
	// Second copy with a blank memory keeps its built-in defaults
	hcs_regs #(.EE_HALF(EE_H)) dut2 (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(), .cfg_retry(),
		.cfg_rdata(cfg_rdata2), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_claim(), .mem_ack(), .mem_rdata(), .mem_fwd(), .mem_fwd_wr(), .mem_fwd_off(), .mem_fwd_wdata(),
		.parity_err_evt(parity_err_evt), .sys_err_evt(sys_err_evt), .irq_src(irq_src), .slave_kind(slave_kind),
		.eeprom_select(), .eeprom_serial_clock(), .eeprom_serial_to_memory(), .eeprom_serial_from_memory(1'b1),
		.cmd_mem_en(), .cmd_int_dis(), .cmd_serr_en(), .cmd_perr_en(), .load_done(load_done2));
	hcs_ee_model #(.WORDS(EE_DATA)) ee (.cs(ee_cs), .sk(ee_sk), .di(ee_di), .dout(ee_do));

	always #12.5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			summarize();
		end
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic cfg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		cfg_req = 1'b1;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_req = 1'b0;
	endtask
	task automatic cfg_chk(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		cfg_op(wr, a, d);
		check({30'h0, cfg_retry, cfg_ack}, 32'h1);
		if (!wr) check(cfg_rdata, exp);
	endtask
	task automatic mem_chk(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic cl,
		input logic [1:0] kind, input logic [31:0] exp);
		logic c;
		@(negedge clk_sys);
		mem_req = 1'b1;
		mem_wr = wr;
		mem_addr = a;
		mem_wdata = d;
		#1;
		c = mem_claim;
		@(negedge clk_sys);
		mem_req = 1'b0;
		check({31'h0, c}, {31'h0, cl});
		check({30'h0, mem_fwd, mem_ack}, {30'h0, kind});
		if (kind == 2'h1 && !wr) check(mem_rdata, exp);
		if (kind == 2'h2) check({18'h0, mem_fwd_off, mem_fwd_wr}, {18'h0, a[12:0], wr});
		if (kind == 2'h2 && wr) check(mem_fwd_wdata, d);
	endtask
	task automatic pulse(input logic sel);
		@(negedge clk_sys);
		parity_err_evt = ~sel;
		sys_err_evt = sel;
		@(negedge clk_sys);
		parity_err_evt = 1'b0;
		sys_err_evt = 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_load();
		int n;
		check({29'h0, ee_cs, ee_sk, ee_di}, 32'h0); // pins idle in reset
		cfg_op(1'b1, 8'h04, 32'h0000_FFFF);
		check({30'h0, cfg_retry, cfg_ack}, 32'h2); // refused while loading
		cfg_op(1'b0, 8'h00, 32'h0);
		check({30'h0, cfg_retry, cfg_ack}, 32'h2); // refused while loading
		for (n = 0; n < 4000 && !(load_done && load_done2); n++) @(negedge clk_sys);
		check({30'h0, load_done, load_done2}, 32'h3); // load finishes
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h0010_0000); // early write had no effect
		$display("test load done");
	endtask
	task automatic t_ident();
		int k;
		cfg_chk(1'b0, 8'h2C, 32'h0, 32'h7081_3C4D); // subsystem words
		check(cfg_rdata2, 32'h0000_0000); // default kept
		cfg_chk(1'b0, 8'h08, 32'h0, 32'h0C03_1001); // class words
		check(cfg_rdata2, 32'h0700_0201); // default kept
		cfg_chk(1'b1, 8'h00, 32'h0, 32'h0); // host write ignored
		for (k = 0; k < 4; k++) begin
			@(negedge clk_sys);
			slave_kind = 2'(k);
			repeat (4) @(negedge clk_sys);
			cfg_chk(1'b0, 8'h00, 32'h0, 32'h5E6F_1A2B); // memory values win
			check(cfg_rdata2, {ids[k], 16'h1F00}); // slave kind picks id
		end
		$display("test ident done");
	endtask
	task automatic t_status();
		cfg_chk(1'b1, 8'h04, 32'h0000_FFFF, 32'h0); // set command
		check({28'h0, cmd_int_dis, cmd_serr_en, cmd_perr_en, cmd_mem_en}, 32'hF); // command bits
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h0010_0542); // read-only zeros
		pulse(1'b0);
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h8010_0542); // parity flag set
		pulse(1'b1);
		cfg_chk(1'b0, 8'h04, 32'h0, 32'hC010_0542); // system flag set
		cfg_chk(1'b1, 8'h04, 32'h0000_0542, 32'h0); // zero write
		cfg_chk(1'b0, 8'h04, 32'h0, 32'hC010_0542); // zero write ignored
		cfg_chk(1'b1, 8'h04, 32'h8000_0542, 32'h0); // clear write
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h4010_0542); // one clears
		cfg_chk(1'b1, 8'h04, 32'h4000_0542, 32'h0); // clear write
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h0010_0542); // one clears
		cfg_chk(1'b1, 8'h04, 32'hFFFF_0542, 32'h0); // write ones
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h0010_0542); // stay zero
		@(negedge clk_sys);
		{cfg_req, cfg_wr, cfg_wdata, parity_err_evt} = {2'b11, 32'h8000_0542, 1'b1};
		@(negedge clk_sys);
		{cfg_req, parity_err_evt} = 2'b00;
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h8010_0542); // set wins over clear
		cfg_be = 4'h7;
		cfg_chk(1'b1, 8'h04, 32'h8000_0542, 32'h0); // top byte disabled
		cfg_be = 4'hF;
		cfg_chk(1'b0, 8'h04, 32'h0, 32'h8010_0542); // flag kept
		$display("test status done");
	endtask
	task automatic t_memory();
		int k;
		cfg_chk(1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0); // write ones
		cfg_chk(1'b0, 8'h10, 32'h0, 32'hFFFF_C000); // base bits only
		cfg_chk(1'b1, 8'h10, BASE, 32'h0); // write base
		cfg_chk(1'b0, 8'h10, 32'h0, BASE); // base stored
		cfg_chk(1'b1, 8'h04, 32'h0000_0540, 32'h0); // decode disabled
		mem_chk(1'b0, BASE + 32'h80, 32'h0, 1'b0, 2'h0, 32'h0); // decode off
		cfg_chk(1'b1, 8'h04, 32'h0000_0542, 32'h0); // decode enabled
		for (k = 0; k < 4; k++) begin
			mem_chk(1'b0, BASE + 32'h80 + 32'(4 * k), 32'h0, 1'b1, 2'h1, irq_src[32 * k +: 32]); // sources
		end
		mem_chk(1'b0, BASE + 32'h2000, 32'h0, 1'b0, 2'h0, 32'h0); // window ends at 8K
		mem_chk(1'b0, 32'h0000_4080, 32'h0, 1'b0, 2'h0, 32'h0); // other base ignored
		mem_chk(1'b0, BASE + 32'h100, 32'h0, 1'b1, 2'h2, 32'h0); // channel space forwarded
		mem_chk(1'b1, BASE + 32'h1FFC, 32'hA5A5_5A5A, 1'b1, 2'h2, 32'h0); // last word forwarded
		$display("test memory done");
	endtask
	task automatic t_eeacc();
		mem_chk(1'b1, BASE + 32'h90, 32'h7, 1'b1, 2'h1, 32'h0); // pins high
		check({29'h0, ee_cs, ee_sk, ee_di}, 32'h7); // software drives pins
		repeat (3) @(negedge clk_sys);
		mem_chk(1'b0, BASE + 32'h90, 32'h0, 1'b1, 2'h1, {28'h0, ee_do, 3'h7}); // pins read back
		mem_chk(1'b1, BASE + 32'h90, 32'h0, 1'b1, 2'h1, 32'h0); // pins low
		check({29'h0, ee_cs, ee_sk, ee_di}, 32'h0); // pins released
		$display("test eeprom access done");
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		t_load();
		t_ident();
		t_status();
		t_memory();
		t_eeacc();
		summarize();
	end
endmodule
